/* hw/rcsosc_pkg.sv */
package rcsosc_pkg;

	// ----------------------------------------------------------------
	// Register indices on the serial port
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_SHDN_CFG = 8'h10; // shutdown_pin_config, first config byte
	localparam logic [7:0] REG_XIN_TUNE = 8'h11; // Crystal input pin tuning code
	localparam logic [7:0] REG_CRYSTAL_DRIVE_OUTPUT_TUNE = 8'h12; // Crystal output pin tuning code
	localparam logic [7:0] REG_SRC_CTRL = 8'h13; // Switchover mode and primary source
	localparam logic [7:0] REG_ADDR_SEL = 8'h14; // Slave address select
	localparam logic [7:0] REG_CFG_END = 8'h15; // One past the last config byte
	localparam logic [7:0] REG_OTP_CMD = 8'h72; // otp_command_control

	// ----------------------------------------------------------------
	// Config array layout and field positions
	// ----------------------------------------------------------------
	localparam int CFG_NUM = 5; // Bytes held in the config array and in OTP
	localparam int OTP_AW = 3; // Index width over the config array
	localparam int SHDN_IDX = 0;
	localparam int XIN_IDX = 1;
	localparam int CRYSTAL_DRIVE_OUTPUT_IDX = 2;
	localparam int SRC_IDX = 3;
	localparam int ADDR_IDX = 4;
	localparam int SHDN_FUNC_BIT = 0; // shutdown_pin_function
	localparam int SHDN_POL_BIT = 1; // shutdown_pin_polarity
	localparam int PRIM_SRC_BIT = 1; // primary_source_bit
	localparam int SM_HI_BIT = 7; // Upper bit of switchover_mode_field [7:6]
	localparam int ADDR_SEL_BIT = 0; // Address select bit
	localparam int OTP_RESTORE_BIT = 0; // Restore command bit
	localparam int OTP_BURN_BIT = 3; // Burn command bit
	localparam int CRYSTAL_TUNING_CODE_W = 6; // crystal_tuning_code width
	localparam logic [OTP_AW-1:0] OTP_LAST = 3'h4; // Index of last config byte
	localparam logic [OTP_AW-1:0] OTP_IDX_ONE = 3'h1;

	// ----------------------------------------------------------------
	// Serial port constants
	// ----------------------------------------------------------------
	localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h6a; // 8-bit form 0xd4
	localparam logic [6:0] I2C_ADDR_ALT = 7'h68; // 8-bit form 0xd0
	localparam logic [7:0] OTP_CMD_SAVE = 8'hf1; // Two-byte save command code
	localparam logic [7:0] OTP_CMD_RESTORE = 8'hf0; // Two-byte restore command code
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic OUT_SHDN_LEVEL = 1'b0; // Outputs low in shutdown
	localparam logic OUT_OE_LEVEL = 1'b0; // Static level when disabled

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [7:0] {
		ST_BOOT = 8'h01, ST_IDLE = 8'h02, ST_DEV = 8'h04, ST_PTR = 8'h08,
		ST_WR = 8'h10, ST_RD = 8'h20, ST_SKIP = 8'h40, ST_OTP = 8'h80
	} rcsosc_state_t;

	typedef struct packed {
		logic [CRYSTAL_TUNING_CODE_W-1:0] xin;
		logic [CRYSTAL_TUNING_CODE_W-1:0] crystal_drive_output;
	} rcsosc_crystal_tuning_code_t;

	typedef struct packed {
		rcsosc_state_t st;
		logic scl_q;
		logic sda_q;
		logic [3:0] bitcnt;
		logic ack_ph;
		logic ack_drv;
		logic [7:0] shreg;
		logic [7:0] txb;
		logic [7:0] ptr;
		logic [7:0] first_b;
		logic [1:0] nbytes;
		logic [CFG_NUM-1:0][7:0] cfg;
		logic burn;
		logic restore;
		logic otp_ph;
		logic [OTP_AW-1:0] otp_idx;
		logic src_sel;
		logic shdn;
		logic ostop;
		logic olevel;
		logic busy;
		logic sda_oe_n;
		rcsosc_crystal_tuning_code_t crystal_tuning_code;
	} rcsosc_ctrl_state_t;

	localparam rcsosc_ctrl_state_t CTRL_RST = '{st: ST_BOOT, scl_q: 1'b1, sda_q: 1'b1,
		restore: 1'b1, busy: 1'b1, sda_oe_n: 1'b1, default: '0};

endpackage

/* hw/rcsosc_otp_mem.sv */
`timescale 1ns/1ps
module rcsosc_otp_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 5,
	parameter int AW = 3
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	output logic [WIDTH-1:0] rd_data_o
);
	// ----------------------------------------------------------------
	// Storage; a blank array reads as zero
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] cells; // Stored words
		logic [WIDTH-1:0] rdata; // Registered read port
	} rcsosc_mem_state_t;

	localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
	rcsosc_mem_state_t mem_reg;
	rcsosc_mem_state_t mem_next;
	logic in_range;

	assign in_range = {1'b0, addr_i} < DEPTH_W;
	assign rd_data_o = mem_reg.rdata;

	// Write and read in one cycle; read data lag the address by one edge
	always_comb begin
		mem_next = mem_reg;
		if (wr_en_i && in_range) begin
			mem_next.cells[addr_i] = wr_data_i;
		end
		mem_next.rdata = in_range ? mem_reg.cells[addr_i] : '0;
	end

	// State register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mem_reg <= '0;
		end else begin
			mem_reg <= mem_next;
		end
	end
endmodule // rcsosc_otp_mem

/* hw/rcsosc_clk_mux.sv */
`timescale 1ns/1ps
module rcsosc_clk_mux (
	input wire logic clk_a_i,
	input wire logic clk_b_i,
	input wire logic resetn_i,
	input wire logic sel_b_i,
	output logic clk_o
);
	// ----------------------------------------------------------------
	// Glitch-free switch between two free-running references
	// ----------------------------------------------------------------
	logic a_sync_reg; // First stage, source A domain
	logic a_en_reg; // Gate enable, changes only while clock A is low
	logic b_sync_reg; // First stage, source B domain
	logic b_en_reg; // Gate enable, changes only while clock B is low

	// Side A wants the path only once side B has let go
	always_ff @(posedge clk_a_i or negedge resetn_i) begin
		if (!resetn_i) begin
			a_sync_reg <= 1'b0;
		end else begin
			a_sync_reg <= ~sel_b_i & ~b_en_reg;
		end
	end

	// Falling-edge stage so the gate opens and shuts with A low
	always_ff @(negedge clk_a_i or negedge resetn_i) begin
		if (!resetn_i) begin
			a_en_reg <= 1'b0;
		end else begin
			a_en_reg <= a_sync_reg;
		end
	end

	// Side B mirror of the above
	always_ff @(posedge clk_b_i or negedge resetn_i) begin
		if (!resetn_i) begin
			b_sync_reg <= 1'b0;
		end else begin
			b_sync_reg <= sel_b_i & ~a_en_reg;
		end
	end

	always_ff @(negedge clk_b_i or negedge resetn_i) begin
		if (!resetn_i) begin
			b_en_reg <= 1'b0;
		end else begin
			b_en_reg <= b_sync_reg;
		end
	end

	// Both gates never open together, so no runt reaches the output
	assign clk_o = (clk_a_i & a_en_reg) | (clk_b_i & b_en_reg);

	gate_exclusive_a: assert property (@(posedge clk_a_i) disable iff (!resetn_i)
		!(a_en_reg && b_en_reg)) else $error("both clock gates open");
endmodule // rcsosc_clk_mux

/* hw/rcsosc_ctrl.sv */
// Functional notes
// - Route crystal or differential input to PLL
// - Either input may be the primary source
// - Switchover field 0x selects manual mode
// - Select pin toggles primary and secondary
// - Source equals select pin XOR primary bit
// - Source change never glitches output clock
// - Six-bit tuning code, 0.5 pF per step
// - Separate codes for crystal input and output
// - Burn bit copies config into OTP
// - Restore bit reloads config from OTP
// - Run after STOP, no acknowledge while busy
// - Restore OTP at power-up before serving bus
// - Address acknowledge means ready for programming
// - Slave address default 0xD4, select gives 0xD0
// - Polarity bit sets shutdown pin active level
// - Function bit picks shutdown or output enable
// - Shutdown drives all single-ended outputs low
// - Disable holds outputs at driven static level
`timescale 1ns/1ps
module rcsosc_ctrl
	import rcsosc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic crystal_or_single_ended_input_i,
	input wire logic differential_ref_true_i,
	input wire logic differential_ref_complement_i,
	input wire logic clock_source_select_pin_i,
	input wire logic shutdown_enable_pin_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	output logic pll_ref_clk_o,
	output rcsosc_crystal_tuning_code_t crystal_tuning_code_o,
	output logic pll_shutdown_o,
	output logic outputs_stopped_o,
	output logic output_static_level_o,
	output logic otp_busy_o
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	rcsosc_ctrl_state_t r; // Whole controller state
	rcsosc_ctrl_state_t n; // Next state
	logic start_det; // SDA falls while SCL high
	logic stop_det; // SDA rises while SCL high
	logic scl_rise;
	logic scl_fall;
	logic bus_live; // Serial port served only outside OTP work
	logic cmd_save; // Two-byte save request seen
	logic cmd_restore; // Two-byte restore request seen
	logic launch; // Start an OTP operation at this STOP
	logic byte_done; // Eighth bit clocked, ack slot opens
	logic wr_now; // Data byte accepted in this cycle
	logic in_cfg; // Pointer inside the config array
	logic [7:0] cfg_off; // Pointer relative to config base
	logic [7:0] rd_byte; // Read data for the current pointer
	logic [6:0] dev_addr; // Live slave address
	logic pin_act; // Shared pin asserted after polarity
	logic diff_clk; // Differential receiver output
	logic mem_wr_en;
	logic [7:0] mem_rd;

	// ----------------------------------------------------------------
	// Bus event decode
	// ----------------------------------------------------------------
	assign start_det = r.scl_q & scl_i & r.sda_q & ~sda_i;
	assign stop_det = r.scl_q & scl_i & ~r.sda_q & sda_i;
	assign scl_rise = ~r.scl_q & scl_i;
	assign scl_fall = r.scl_q & ~scl_i;
	assign bus_live = (r.st != ST_BOOT) && (r.st != ST_OTP);
	assign byte_done = scl_fall & ~r.ack_ph & (r.bitcnt == BYTE_BITS);
	assign wr_now = byte_done & (r.st == ST_WR);
	// Address byte followed by exactly one command byte
	assign cmd_save = (r.st == ST_WR) && (r.nbytes == 2'h1) && (r.first_b == OTP_CMD_SAVE);
	assign cmd_restore = (r.st == ST_WR) && (r.nbytes == 2'h1)
		&& (r.first_b == OTP_CMD_RESTORE);
	assign launch = stop_det & bus_live & (cmd_save | cmd_restore | r.burn | r.restore);

	// ----------------------------------------------------------------
	// Register map decode
	// ----------------------------------------------------------------
	assign cfg_off = r.ptr - REG_SHDN_CFG;
	assign in_cfg = (r.ptr >= REG_SHDN_CFG) && (r.ptr < REG_CFG_END);
	assign dev_addr = r.cfg[ADDR_IDX][ADDR_SEL_BIT] ? I2C_ADDR_ALT : I2C_ADDR_DEFAULT;
	// Config bytes and pending command bits read back; other indices read zero
	assign rd_byte = in_cfg ? r.cfg[cfg_off[OTP_AW-1:0]] :
		(r.ptr == REG_OTP_CMD) ? (({7'h00, r.burn} << OTP_BURN_BIT)
		| ({7'h00, r.restore} << OTP_RESTORE_BIT)) : 8'h00;
	assign pin_act = r.cfg[SHDN_IDX][SHDN_POL_BIT] ? shutdown_enable_pin_i
		: ~shutdown_enable_pin_i;

	// ----------------------------------------------------------------
	// OTP store and source mux
	// ----------------------------------------------------------------
	// Burn writes in the first half of each two-cycle slot
	assign mem_wr_en = ~bus_live & ~r.restore & ~r.otp_ph;

	rcsosc_otp_mem #(
		.WIDTH(8),
		.DEPTH(CFG_NUM),
		.AW(OTP_AW)
	) u_otp (
		.clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.wr_en_i(mem_wr_en),
		.addr_i(r.otp_idx),
		.wr_data_i(r.cfg[r.otp_idx]),
		.rd_data_o(mem_rd)
	);

	// Complement acts as the comparator's reference leg
	assign diff_clk = differential_ref_true_i & ~differential_ref_complement_i;

	rcsosc_clk_mux u_mux (
		.clk_a_i(crystal_or_single_ended_input_i),
		.clk_b_i(diff_clk),
		.resetn_i(resetn_i),
		.sel_b_i(r.src_sel),
		.clk_o(pll_ref_clk_o)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		n.scl_q = scl_i;
		n.sda_q = sda_i;
		if (!bus_live) begin
			// OTP engine: address slot, then data slot, per byte
			if (r.otp_ph) begin
				if (r.restore) begin
					n.cfg[r.otp_idx] = mem_rd;
				end
				if (r.otp_idx == OTP_LAST) begin
					// Done; the bus is answered again from here
					n.st = ST_IDLE;
					n.burn = 1'b0;
					n.restore = 1'b0;
					n.otp_idx = '0;
				end else begin
					n.otp_idx = r.otp_idx + OTP_IDX_ONE;
				end
			end
			n.otp_ph = ~r.otp_ph;
			n.ack_ph = 1'b0;
			n.ack_drv = 1'b0;
		end else if (start_det) begin
			// Start or repeated start
			n.st = ST_DEV;
			n.bitcnt = '0;
			n.ack_ph = 1'b0;
			n.ack_drv = 1'b0;
			n.nbytes = '0;
		end else if (stop_det) begin
			// Register writes are already in; commands run now
			if (launch) begin
				n.st = ST_OTP;
				n.burn = r.burn | cmd_save;
				n.restore = r.restore | cmd_restore;
				n.otp_ph = 1'b0;
				n.otp_idx = '0;
			end else begin
				n.st = ST_IDLE;
			end
			n.ack_ph = 1'b0;
			n.ack_drv = 1'b0;
		end else if ((r.st == ST_DEV) || (r.st == ST_PTR) || (r.st == ST_WR)
			|| (r.st == ST_RD)) begin
			if (scl_rise) begin
				if (!r.ack_ph) begin
					// Data bit, MSB first
					n.shreg = {r.shreg[6:0], sda_i};
					n.bitcnt = r.bitcnt + 4'h1;
				end else if ((r.st == ST_RD) && sda_i) begin
					// Master refused more data
					n.st = ST_SKIP;
				end
			end
			if (byte_done) begin
				n.ack_ph = 1'b1;
				case (r.st)
					ST_DEV: begin
						if (r.shreg[7:1] == dev_addr) begin
							n.ack_drv = 1'b1;
							n.st = r.shreg[0] ? ST_RD : ST_PTR;
						end else begin
							n.st = ST_SKIP;
						end
					end
					ST_PTR: begin
						n.ptr = r.shreg;
						n.first_b = r.shreg;
						n.nbytes = 2'h1;
						n.st = ST_WR;
						n.ack_drv = 1'b1;
					end
					ST_WR: begin
						if (in_cfg) begin
							n.cfg[cfg_off[OTP_AW-1:0]] = r.shreg;
						end
						if (r.ptr == REG_OTP_CMD) begin
							n.burn = r.burn | r.shreg[OTP_BURN_BIT];
							n.restore = r.restore | r.shreg[OTP_RESTORE_BIT];
						end
						n.ptr = r.ptr + 8'h01;
						if (r.nbytes != 2'h3) begin
							n.nbytes = r.nbytes + 2'h1;
						end
						n.ack_drv = 1'b1;
					end
					default: begin
						n.ack_drv = 1'b0; // Master acks read bytes
					end
				endcase
			end else if (scl_fall && r.ack_ph) begin
				// Ack slot over; a read loads the next byte
				n.ack_ph = 1'b0;
				n.ack_drv = 1'b0;
				n.bitcnt = '0;
				if (r.st == ST_RD) begin
					n.txb = rd_byte;
					n.ptr = r.ptr + 8'h01;
				end
			end else if (scl_fall && (r.st == ST_RD)) begin
				// Next read bit moves out only while SCL is low; a change
				// while SCL is high would look like START or STOP
				n.txb = {r.txb[6:0], 1'b0};
			end
		end

		// Source choice: manual mode follows the pin, otherwise the primary
		if (!r.cfg[SRC_IDX][SM_HI_BIT]) begin
			n.src_sel = clock_source_select_pin_i ^ r.cfg[SRC_IDX][PRIM_SRC_BIT];
		end else begin
			n.src_sel = r.cfg[SRC_IDX][PRIM_SRC_BIT];
		end

		// Shared pin: shutdown or output enable, both stop outputs
		n.shdn = r.cfg[SHDN_IDX][SHDN_FUNC_BIT] & pin_act;
		n.ostop = pin_act;
		n.olevel = r.cfg[SHDN_IDX][SHDN_FUNC_BIT] ? OUT_SHDN_LEVEL : OUT_OE_LEVEL;
		n.crystal_tuning_code.xin = r.cfg[XIN_IDX][CRYSTAL_TUNING_CODE_W-1:0];
		n.crystal_tuning_code.crystal_drive_output = r.cfg[CRYSTAL_DRIVE_OUTPUT_IDX][CRYSTAL_TUNING_CODE_W-1:0];
		n.busy = (n.st == ST_BOOT) || (n.st == ST_OTP);

		// Open-drain pull: ack slot, or a zero bit of read data
		n.sda_oe_n = ~((n.ack_ph & n.ack_drv)
			| ((n.st == ST_RD) & ~n.ack_ph & ~n.txb[7]));
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Reset enters boot, which restores from OTP before the bus is served
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			r <= CTRL_RST;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign sda_o = 1'b0; // Open drain only ever pulls low
	assign sda_oe_n_o = r.sda_oe_n;
	assign crystal_tuning_code_o = r.crystal_tuning_code;
	assign pll_shutdown_o = r.shdn;
	assign outputs_stopped_o = r.ostop;
	assign output_static_level_o = r.olevel;
	assign otp_busy_o = r.busy;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	src_select_a: assert property (
		!r.cfg[SRC_IDX][SM_HI_BIT] |=> r.src_sel == ($past(clock_source_select_pin_i)
		^ $past(r.cfg[SRC_IDX][PRIM_SRC_BIT])))
		else $error("source select not pin xor primary");

	shdn_drive_a: assert property (
		(r.cfg[SHDN_IDX][SHDN_FUNC_BIT] && pin_act)
		|=> pll_shutdown_o && outputs_stopped_o && !output_static_level_o)
		else $error("shutdown did not drive outputs low");

	oe_static_a: assert property (
		(!r.cfg[SHDN_IDX][SHDN_FUNC_BIT] && pin_act)
		|=> outputs_stopped_o && !pll_shutdown_o && (output_static_level_o == OUT_OE_LEVEL))
		else $error("disable did not hold static level");

	pin_polarity_a: assert property (
		!shutdown_enable_pin_i |=> outputs_stopped_o == !$past(r.cfg[SHDN_IDX][SHDN_POL_BIT]))
		else $error("shared pin polarity wrong");

	boot_quiet_a: assert property (
		r.st == ST_BOOT |=> sda_oe_n_o)
		else $error("bus answered during boot restore");

	boot_load_a: assert property (
		r.st == ST_BOOT |-> ##[1:12] r.st == ST_IDLE)
		else $error("boot restore too long");

	otp_quiet_a: assert property (
		r.st == ST_OTP |=> sda_oe_n_o)
		else $error("acknowledge during otp work");

	otp_launch_a: assert property (
		launch |=> r.st == ST_OTP ##1 otp_busy_o)
		else $error("otp command not started at stop");

	otp_finish_a: assert property (
		(r.st == ST_OTP && $past(r.st) != ST_OTP) |-> ##[1:12] (r.st == ST_IDLE && !r.burn)
		) else $error("otp operation did not finish");

	addr_ack_a: assert property (
		(r.st == ST_DEV && byte_done && r.shreg[7:1] == dev_addr) |=> !sda_oe_n_o)
		else $error("own address not acknowledged");

	crystal_tuning_code_write_a: assert property (
		(wr_now && r.ptr == REG_XIN_TUNE)
		|=> ##1 crystal_tuning_code_o.xin == $past(r.shreg[CRYSTAL_TUNING_CODE_W-1:0], 2))
		else $error("tuning code not applied");
endmodule // rcsosc_ctrl

/* tb/rcsosc_bfm.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus master and reference clock sources
// ----------------------------------------------------------------
module rcsosc_bfm (
	input wire logic clk_i,
	input wire logic sda_o_i,
	input wire logic sda_oe_n_i,
	output logic scl_o,
	output logic sda_o,
	output logic ref_a_o,
	output logic diff_t_o,
	output logic diff_c_o
);
	logic sda_drv; // Master side of the open-drain data line
	// Pull-up wins unless someone pulls low
	assign sda_o = sda_drv & (sda_oe_n_i | sda_o_i);
	assign diff_c_o = ~diff_t_o;
	initial begin
		scl_o = 1'b1;
		sda_drv = 1'b1;
		ref_a_o = 1'b0;
		diff_t_o = 1'b0;
	end
	// Free-running references; the 40 ns period is twice that of clk_i, the 110 ns one is unrelated to either
	always #20 ref_a_o = ~ref_a_o;
	always #55 diff_t_o = ~diff_t_o;
	// Quarter bit, above the three-cycle minimum per phase
	task automatic q();
		repeat (4) @(posedge clk_i);
		#2;
	endtask
	// Data falls while clock high
	task automatic start();
		sda_drv = 1'b1;
		q();
		scl_o = 1'b1;
		q();
		sda_drv = 1'b0;
		q();
		scl_o = 1'b0;
		q();
	endtask
	// Data rises while clock high
	task automatic stop();
		sda_drv = 1'b0;
		q();
		scl_o = 1'b1;
		q();
		sda_drv = 1'b1;
		q();
	endtask
	// Data changes only while clock is low, sampled mid-high
	task automatic bit_x(input logic b, output logic r);
		sda_drv = b;
		q();
		scl_o = 1'b1;
		q();
		r = sda_o;
		q();
		scl_o = 1'b0;
		q();
	endtask
	// MSB first, then the acknowledge slot with data released
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(b[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask
	// Last byte gets a NACK so the slave lets go
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(last, r);
	endtask
endmodule // rcsosc_bfm

/* tb/test_ref_clock_select_otp_shutdown_ctrl.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module test_ref_clock_select_otp_shutdown_ctrl;
	import rcsosc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic sel_pin = 1'b0; // Source select pin level
	logic sd_pin = 1'b1; // Shared pin, idle for active-low default
	logic scl, sda, sda_o, sda_oe_n, pll_clk, ref_a, dt, dc, pll_sd, stopped, lvl, busy;
	rcsosc_crystal_tuning_code_t tune;
	int mismatches = 0;
	int check_count = 0;
	int edges = 0; // Rising edges seen on the mux output
	realtime t_edge = 0;
	logic [15:0] expq[$];
	logic [15:0] obsq[$];
	always #10 ref_clk_i = ~ref_clk_i;
	rcsosc_ctrl i_rcsosc_ctrl (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.crystal_or_single_ended_input_i(ref_a), .differential_ref_true_i(dt),
		.differential_ref_complement_i(dc), .clock_source_select_pin_i(sel_pin),
		.shutdown_enable_pin_i(sd_pin), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n), .pll_ref_clk_o(pll_clk), .crystal_tuning_code_o(tune),
		.pll_shutdown_o(pll_sd), .outputs_stopped_o(stopped),
		.output_static_level_o(lvl), .otp_busy_o(busy));
	rcsosc_bfm i_rcsosc_bfm (.clk_i(ref_clk_i), .sda_o_i(sda_o), .sda_oe_n_i(sda_oe_n),
		.scl_o(scl), .sda_o(sda), .ref_a_o(ref_a), .diff_t_o(dt), .diff_c_o(dc));
	task automatic final_report();
		// Let the checker drain the last notes first
		repeat (2) @(posedge ref_clk_i);
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Driver files the expectation next to what it saw
	task automatic note(input logic [15:0] e, input logic [15:0] o);
		expq.push_back(e);
		obsq.push_back(o);
	endtask
	// Compares each result with the oldest expectation
	initial begin
		logic [15:0] e, o;
		forever begin
			@(posedge ref_clk_i);
			while (obsq.size() > 0) begin
				e = expq.pop_front();
				o = obsq.pop_front();
				check_count++;
				if (o !== e) begin
					mismatches++;
					$display("MISMATCH t=%0t exp=%h got=%h", $time, e, o);
				end
			end
		end
	end
	// A runt would be shorter than the faster reference half period
	always @(pll_clk) begin
		if (resetn_i && ($realtime - t_edge) < 19.0) note(16'h0, 16'hbad);
		t_edge = $realtime;
	end
	always @(posedge pll_clk) edges++;
	// Bounded wait for the busy flag to reach a level
	task automatic wait_busy(input logic lv);
		int n;
		n = 0;
		while (busy !== lv) begin
			@(posedge ref_clk_i);
			#2;
			n++;
			if (n > 60) begin
				mismatches++;
				final_report();
			end
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d,
		output logic ak);
		logic x;
		i_rcsosc_bfm.start();
		i_rcsosc_bfm.wbyte(a, ak);
		i_rcsosc_bfm.wbyte(p, x);
		i_rcsosc_bfm.wbyte(d, x);
		i_rcsosc_bfm.stop();
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic x;
		i_rcsosc_bfm.start();
		i_rcsosc_bfm.wbyte(8'hd4, x);
		i_rcsosc_bfm.wbyte(p, x);
		i_rcsosc_bfm.start();
		i_rcsosc_bfm.wbyte(8'hd5, x);
		i_rcsosc_bfm.rbyte(1'b1, d);
		i_rcsosc_bfm.stop();
	endtask
	// Two bytes only, then stay off the bus until the work is done
	task automatic cmd(input logic [7:0] c);
		logic x;
		i_rcsosc_bfm.start();
		i_rcsosc_bfm.wbyte(8'hd4, x);
		i_rcsosc_bfm.wbyte(c, x);
		i_rcsosc_bfm.stop();
		wait_busy(1'b1);
		wait_busy(1'b0);
	endtask
	initial begin
		logic ak, a, s;
		logic [7:0] d, xi, xo;
		void'($urandom(90));
		repeat (10) @(posedge ref_clk_i);
		#2 resetn_i = 1'b1;
		@(posedge ref_clk_i);
		#2;
		note(16'h1, {15'h0, busy});
		wait_busy(1'b0);
		note(16'h0, {4'h0, tune});
		$display("Test reset done");
		xi = 8'($urandom % 64);
		xo = 8'($urandom % 64);
		wr(8'hd4, REG_XIN_TUNE, xi, ak);
		note(16'h1, {15'h0, ak});
		wr(8'hd4, REG_CRYSTAL_DRIVE_OUTPUT_TUNE, xo, ak);
		note({4'h0, xi[5:0], xo[5:0]}, {4'h0, tune});
		rd(REG_XIN_TUNE, d);
		note({8'h0, xi}, {8'h0, d});
		rd(8'h20, d);
		note(16'h0, {8'h0, d});
		$display("Test tuning done");
		cmd(OTP_CMD_SAVE);
		wr(8'hd4, REG_XIN_TUNE, 8'h3f, ak);
		note(16'h1, {15'h0, ak});
		cmd(OTP_CMD_RESTORE);
		note({4'h0, xi[5:0], xo[5:0]}, {4'h0, tune});
		wr(8'hd4, REG_XIN_TUNE, 8'h00, ak);
		wr(8'hd4, REG_OTP_CMD, 8'h01, ak);
		wait_busy(1'b1);
		wait_busy(1'b0);
		note({4'h0, xi[5:0], xo[5:0]}, {4'h0, tune});
		wr(8'hd4, REG_XIN_TUNE, 8'h2a, ak);
		wr(8'hd4, REG_OTP_CMD, 8'h08, ak);
		wait_busy(1'b1);
		wait_busy(1'b0);
		rd(REG_OTP_CMD, d);
		note(16'h0, {8'h0, d});
		wr(8'hd4, REG_XIN_TUNE, 8'h00, ak);
		cmd(OTP_CMD_RESTORE);
		note({4'h0, 6'h2a, xo[5:0]}, {4'h0, tune});
		$display("Test otp done");
		wr(8'hd4, REG_ADDR_SEL, 8'h01, ak);
		wr(8'hd4, REG_XIN_TUNE, 8'h05, ak);
		note(16'h0, {15'h0, ak});
		wr(8'hd0, REG_ADDR_SEL, 8'h00, ak);
		note(16'h1, {15'h0, ak});
		$display("Test address done");
		for (int m = 0; m < 4; m++) begin
			wr(8'hd4, REG_SHDN_CFG, 8'(m), ak);
			for (int p = 0; p < 2; p++) begin
				sd_pin = p[0];
				repeat (3) @(posedge ref_clk_i);
				#2;
				a = (p[0] == m[1]);
				note({13'h0, m[0] & a, a, 1'b0}, {13'h0, pll_sd, stopped, lvl});
			end
		end
		sd_pin = 1'b1;
		wr(8'hd4, REG_SHDN_CFG, 8'h00, ak);
		$display("Test shared pin done");
		for (int k = 0; k < 8; k++) begin
			wr(8'hd4, REG_SRC_CTRL, {k[2], 5'h0, k[1], 1'b0}, ak);
			sel_pin = k[0];
			repeat (20) @(posedge ref_clk_i);
			edges = 0;
			repeat (100) @(posedge ref_clk_i);
			s = k[2] ? k[1] : (k[0] ^ k[1]);
			note({15'h0, s}, {15'h0, edges < 34});
		end
		$display("Test source done");
		final_report();
	end
endmodule // test_ref_clock_select_otp_shutdown_ctrl
